// >>> design/speed_tune_pkg.sv
`default_nettype none
package speed_tune_pkg;

   // ----------------------------------------------------------------
   // Parameter addresses
   // ----------------------------------------------------------------
   localparam logic [15:0] ADDR_FIRST_GAIN = 16'h0200;
   localparam logic [15:0] ADDR_PROP_GAIN  = 16'h0208;
   localparam logic [15:0] ADDR_INTEG_GAIN = 16'h020c;
   localparam logic [15:0] ADDR_FF_GAIN    = 16'h020e;
   localparam logic [15:0] ADDR_FILT_A     = 16'h0250;
   localparam logic [15:0] ADDR_FILT_B     = 16'h0252;
   localparam logic [15:0] ADDR_STIFFNESS  = 16'h0254;
   localparam logic [15:0] ADDR_MODE       = 16'h0240;
   localparam logic [15:0] ADDR_STABLE     = 16'h0256;
   localparam logic [15:0] ADDR_INERTIA    = 16'h0258;

   // ----------------------------------------------------------------
   // Ranges and reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] PROP_MAX      = 16'h1fff;
   localparam logic [15:0] INTEG_MAX     = 16'h03ff;
   localparam logic [15:0] FF_MAX        = 16'h0064;
   localparam logic [15:0] MODE_MAX      = 16'h0002;
   localparam logic [15:0] PROP_RESET    = 16'h01f4;
   localparam logic [15:0] INTEG_RESET   = 16'h0064;
   localparam logic [15:0] FF_RESET      = 16'h0000;
   localparam logic [15:0] GAIN_RESET    = 16'h0000;
   localparam logic [15:0] INERTIA_RESET = 16'h000a;
   localparam logic [15:0] FF_PERCENT    = 16'h0064;

   // ----------------------------------------------------------------
   // Mode codes and timing
   // ----------------------------------------------------------------
   localparam logic [15:0] MODE_MANUAL = 16'h0000;
   localparam logic [15:0] MODE_AUTO   = 16'h0001;
   localparam logic [15:0] MODE_SEMI   = 16'h0002;

   localparam longint SAVE_MINUTES = 30;
   localparam longint CLK_HZ       = 25_000_000;
   localparam logic [39:0] SAVE_CYCLES = 40'(SAVE_MINUTES * 60 * CLK_HZ);

   typedef enum logic [2:0] {
      ST_MANUAL = 3'b001,
      ST_AUTO   = 3'b010,
      ST_SEMI   = 3'b100
   } tune_state_e;

   typedef struct packed {
      logic [15:0] first_gain;
      logic [15:0] prop_gain;
      logic [15:0] integ_gain;
      logic [15:0] filt_a;
      logic [15:0] filt_b;
   } gain_set_s;

endpackage
`default_nettype wire

// >>> design/speed_tune.sv
// How it works
// - Mode selector takes 0 manual, 1 continuous auto, 2 semi-auto only.
// - Manual mode turns off all automatic gain adjustment.
// - Manual mode accepts user writes to every gain parameter.
// - Auto mode estimates inertia and saves the ratio every 30 minutes.
// - Leaving auto or semi-auto for manual saves the current inertia estimate.
// - Auto to manual copies first, proportional and integral gains from auto.
// - Semi-auto to manual also copies both filter gains.
// - Semi-auto stable estimate sets flag, stops estimation, saves inertia.
// - Entering semi-auto restarts inertia estimation.
// - Semi-auto inertia out of range clears flag and resumes estimation.
// - Proportional gain is 16 bits, 0 to 8191, reset 500.
// - Integral gain is 16 bits, 0 to 1023, reset 100.
// - Feed-forward gain is 16 bits, 0 to 100 percent, reset 0.
`timescale 1ns/1ps
`default_nettype none
module speed_tune #(
   parameter logic [39:0] SAVE_CYCLES = speed_tune_pkg::SAVE_CYCLES
) (
   input  wire logic                      core_clk,
   input  wire logic                      arst_n,
   input  wire logic                      ce,
   input  wire logic                      param_wr,
   input  wire logic                      param_rd,
   input  wire logic [15:0]               param_addr,
   input  wire logic [15:0]               param_wdata,
   output logic      [15:0]               param_rdata,
   input  wire logic [15:0]               est_inertia,
   input  wire logic                      est_stable,
   input  wire logic                      est_out_of_range,
   input  wire speed_tune_pkg::gain_set_s est_gains,
   output logic                           est_run,
   output logic                           est_restart,
   output logic      [15:0]               stiffness,
   input  wire logic signed [15:0]        speed_cmd,
   input  wire logic signed [15:0]        speed_fb,
   output logic signed [41:0]             ctrl_out
);

   // ----------------------------------------------------------------
   // Parameter store and mode
   // ----------------------------------------------------------------
   speed_tune_pkg::tune_state_e state;
   speed_tune_pkg::gain_set_s   gains;
   logic [15:0] ff_gain;
   logic [15:0] inertia;
   logic        stable;
   logic [39:0] save_cnt;
   logic        save_tick;
   logic [15:0] mode_code;
   logic        wr_mode_ok;
   logic        to_manual;
   logic        manual;

   assign manual = (state == speed_tune_pkg::ST_MANUAL);
   assign save_tick = (state == speed_tune_pkg::ST_AUTO)
                      && (save_cnt == SAVE_CYCLES - 40'h1);
   assign wr_mode_ok = param_wr && (param_addr == speed_tune_pkg::ADDR_MODE)
                       && (param_wdata <= speed_tune_pkg::MODE_MAX);
   assign to_manual = wr_mode_ok && !manual
                      && (param_wdata == speed_tune_pkg::MODE_MANUAL);

   always_comb
   begin
      case (state)
         speed_tune_pkg::ST_AUTO: mode_code = speed_tune_pkg::MODE_AUTO;
         speed_tune_pkg::ST_SEMI: mode_code = speed_tune_pkg::MODE_SEMI;
         default:                 mode_code = speed_tune_pkg::MODE_MANUAL;
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         state <= speed_tune_pkg::ST_MANUAL;
      else if (ce && wr_mode_ok)
      begin
         case (param_wdata)
            speed_tune_pkg::MODE_AUTO: state <= speed_tune_pkg::ST_AUTO;
            speed_tune_pkg::MODE_SEMI: state <= speed_tune_pkg::ST_SEMI;
            default:                   state <= speed_tune_pkg::ST_MANUAL;
         endcase
      end
   end

   // Gains: user writes only in manual, copied from the tuner on exit
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         gains.first_gain <= speed_tune_pkg::GAIN_RESET;
         gains.prop_gain  <= speed_tune_pkg::PROP_RESET;
         gains.integ_gain <= speed_tune_pkg::INTEG_RESET;
         gains.filt_a     <= speed_tune_pkg::GAIN_RESET;
         gains.filt_b     <= speed_tune_pkg::GAIN_RESET;
      end
      else if (ce && to_manual)
      begin
         gains.first_gain <= est_gains.first_gain;
         gains.prop_gain  <= est_gains.prop_gain;
         gains.integ_gain <= est_gains.integ_gain;
         if (state == speed_tune_pkg::ST_SEMI)
         begin
            gains.filt_a <= est_gains.filt_a;
            gains.filt_b <= est_gains.filt_b;
         end
      end
      else if (ce && param_wr && manual)
      begin
         case (param_addr)
            speed_tune_pkg::ADDR_FIRST_GAIN:
               gains.first_gain <= param_wdata;
            speed_tune_pkg::ADDR_PROP_GAIN:
               if (param_wdata <= speed_tune_pkg::PROP_MAX)
                  gains.prop_gain <= param_wdata;
            speed_tune_pkg::ADDR_INTEG_GAIN:
               if (param_wdata <= speed_tune_pkg::INTEG_MAX)
                  gains.integ_gain <= param_wdata;
            speed_tune_pkg::ADDR_FILT_A:
               gains.filt_a <= param_wdata;
            speed_tune_pkg::ADDR_FILT_B:
               gains.filt_b <= param_wdata;
            default:
               gains.first_gain <= gains.first_gain;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ff_gain   <= speed_tune_pkg::FF_RESET;
         stiffness <= speed_tune_pkg::GAIN_RESET;
      end
      else if (ce && param_wr)
      begin
         if (param_addr == speed_tune_pkg::ADDR_FF_GAIN
             && param_wdata <= speed_tune_pkg::FF_MAX)
            ff_gain <= param_wdata;
         if (param_addr == speed_tune_pkg::ADDR_STIFFNESS)
            stiffness <= param_wdata;
      end
   end

   // ----------------------------------------------------------------
   // Inertia estimation control
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         save_cnt <= 40'h0;
      else if (ce)
      begin
         if (state != speed_tune_pkg::ST_AUTO || save_tick)
            save_cnt <= 40'h0;
         else
            save_cnt <= save_cnt + 40'h1;
      end
   end

   // Hardware saves win over a user write in the same cycle
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         inertia <= speed_tune_pkg::INERTIA_RESET;
      else if (ce)
      begin
         if (to_manual || save_tick)
            inertia <= est_inertia;
         else if (state == speed_tune_pkg::ST_SEMI && !stable && est_stable)
            inertia <= est_inertia;
         else if (param_wr && param_addr == speed_tune_pkg::ADDR_INERTIA)
            inertia <= param_wdata;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stable      <= 1'b0;
         est_restart <= 1'b0;
      end
      else if (ce)
      begin
         est_restart <= 1'b0;
         if (wr_mode_ok && param_wdata == speed_tune_pkg::MODE_SEMI
             && state != speed_tune_pkg::ST_SEMI)
         begin
            stable      <= 1'b0;
            est_restart <= 1'b1;
         end
         else if (state != speed_tune_pkg::ST_SEMI)
            stable <= 1'b0;
         else if (est_out_of_range)
            stable <= 1'b0;
         else if (est_stable)
            stable <= 1'b1;
      end
   end

   assign est_run = !manual && !stable;

   // ----------------------------------------------------------------
   // Parameter read
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         param_rdata <= 16'h0000;
      else if (ce && param_rd)
      begin
         case (param_addr)
            speed_tune_pkg::ADDR_FIRST_GAIN: param_rdata <= gains.first_gain;
            speed_tune_pkg::ADDR_PROP_GAIN:  param_rdata <= gains.prop_gain;
            speed_tune_pkg::ADDR_INTEG_GAIN: param_rdata <= gains.integ_gain;
            speed_tune_pkg::ADDR_FF_GAIN:    param_rdata <= ff_gain;
            speed_tune_pkg::ADDR_FILT_A:     param_rdata <= gains.filt_a;
            speed_tune_pkg::ADDR_FILT_B:     param_rdata <= gains.filt_b;
            speed_tune_pkg::ADDR_STIFFNESS:  param_rdata <= stiffness;
            speed_tune_pkg::ADDR_MODE:       param_rdata <= mode_code;
            speed_tune_pkg::ADDR_STABLE:     param_rdata <= {15'h0, stable};
            speed_tune_pkg::ADDR_INERTIA:    param_rdata <= inertia;
            default:                         param_rdata <= 16'h0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Speed controller
   // ----------------------------------------------------------------
   logic        [15:0] kp_eff;
   logic        [15:0] ki_eff;
   logic signed [16:0] err;
   logic signed [23:0] integ;
   logic signed [41:0] p_term;
   logic signed [41:0] i_term;
   logic signed [41:0] f_term;

   assign kp_eff = manual ? gains.prop_gain : est_gains.prop_gain;
   assign ki_eff = manual ? gains.integ_gain : est_gains.integ_gain;
   assign err = 17'(speed_cmd) - 17'(speed_fb);
   assign p_term = 42'($signed({1'b0, kp_eff}) * err);
   assign i_term = 42'(integ * $signed({1'b0, ki_eff}));
   assign f_term = 42'((speed_cmd * $signed({1'b0, ff_gain}))
                       / $signed({1'b0, speed_tune_pkg::FF_PERCENT}));

   // Integrator wraps; keep error bounded in the loop around it
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         integ    <= 24'sh0;
         ctrl_out <= 42'sh0;
      end
      else if (ce)
      begin
         integ    <= integ + 24'(err);
         ctrl_out <= p_term + i_term + f_term;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   mode_range_a: assert property (mode_code <= speed_tune_pkg::MODE_MAX)
      else $error("mode out of range");
   manual_hold_a: assert property (ce && manual && !param_wr
      |=> $stable(gains.prop_gain) && $stable(gains.integ_gain) && !est_run)
      else $error("gain moved in manual mode");
   manual_write_a: assert property (ce && manual && param_wr
      && param_addr == speed_tune_pkg::ADDR_PROP_GAIN
      && param_wdata <= speed_tune_pkg::PROP_MAX
      |=> gains.prop_gain == $past(param_wdata))
      else $error("manual gain write lost");
   auto_save_a: assert property (ce && save_tick
      |=> inertia == $past(est_inertia) && save_cnt == 40'h0)
      else $error("periodic inertia save missing");
   leave_save_a: assert property (ce && to_manual
      |=> manual && inertia == $past(est_inertia))
      else $error("inertia not saved on exit");
   auto_copy_a: assert property (ce && to_manual
      && state == speed_tune_pkg::ST_AUTO
      |=> gains.prop_gain == $past(est_gains.prop_gain)
          && gains.filt_a == $past(gains.filt_a))
      else $error("auto gains not copied");
   semi_copy_a: assert property (ce && to_manual
      && state == speed_tune_pkg::ST_SEMI
      |=> gains == $past(est_gains))
      else $error("semi gains not copied");
   semi_stable_a: assert property (ce && state == speed_tune_pkg::ST_SEMI
      && !wr_mode_ok && !est_out_of_range && est_stable && !stable
      |=> stable && !est_run && inertia == $past(est_inertia))
      else $error("stable flag not set");
   semi_restart_a: assert property (ce && wr_mode_ok
      && param_wdata == speed_tune_pkg::MODE_SEMI
      && state != speed_tune_pkg::ST_SEMI
      |=> est_restart && est_run ##1 !est_restart || !ce)
      else $error("estimation not restarted");
   range_clear_a: assert property (ce && state == speed_tune_pkg::ST_SEMI
      && !wr_mode_ok && est_out_of_range |=> !stable && est_run)
      else $error("stable flag not cleared");
   gain_limits_a: assert property (gains.prop_gain <= speed_tune_pkg::PROP_MAX
      && gains.integ_gain <= speed_tune_pkg::INTEG_MAX
      && ff_gain <= speed_tune_pkg::FF_MAX)
      else $error("gain above range");
   reject_write_a: assert property (ce && param_wr
      && param_addr == speed_tune_pkg::ADDR_FF_GAIN
      && param_wdata > speed_tune_pkg::FF_MAX |=> $stable(ff_gain))
      else $error("bad write accepted");
   ctrl_sum_a: assert property (ce && manual && gains.integ_gain == 16'h0
      && ff_gain == 16'h0
      |=> ctrl_out == 42'($signed({1'b0, $past(gains.prop_gain)}) * $past(err)))
      else $error("controller output wrong");

   enter_auto_c: cover property (ce && wr_mode_ok
      && param_wdata == speed_tune_pkg::MODE_AUTO && manual);
   semi_lock_c: cover property (ce && est_stable
      && state == speed_tune_pkg::ST_SEMI ##1 stable);
   semi_exit_c: cover property (ce && to_manual
      && state == speed_tune_pkg::ST_SEMI);
   save_tick_c: cover property (save_tick);

endmodule
`default_nettype wire

// >>> bench/speed_tune_bench.sv
`timescale 1ns/1ps
`default_nettype none
module speed_tune_bench;
   localparam logic [39:0] SAVE_N = 40'd20;

   logic                      core_clk;
   logic                      arst_n;
   logic                      ce;
   logic                      param_wr;
   logic                      param_rd;
   logic [15:0]               param_addr;
   logic [15:0]               param_wdata;
   logic [15:0]               param_rdata;
   logic [15:0]               est_inertia;
   logic                      est_stable;
   logic                      est_out_of_range;
   speed_tune_pkg::gain_set_s est_gains;
   logic                      est_run;
   logic                      est_restart;
   logic [15:0]               stiffness;
   logic signed [15:0]        speed_cmd;
   logic signed [15:0]        speed_fb;
   logic signed [41:0]        ctrl_out;
   int                        n_mismatch;
   int                        checks;
   int                        pulses;

   speed_tune #(.SAVE_CYCLES(SAVE_N)) i_dut (
      .core_clk         (core_clk),
      .arst_n           (arst_n),
      .ce               (ce),
      .param_wr         (param_wr),
      .param_rd         (param_rd),
      .param_addr       (param_addr),
      .param_wdata      (param_wdata),
      .param_rdata      (param_rdata),
      .est_inertia      (est_inertia),
      .est_stable       (est_stable),
      .est_out_of_range (est_out_of_range),
      .est_gains        (est_gains),
      .est_run          (est_run),
      .est_restart      (est_restart),
      .stiffness        (stiffness),
      .speed_cmd        (speed_cmd),
      .speed_fb         (speed_fb),
      .ctrl_out         (ctrl_out)
   );

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string nm, input logic [41:0] exp,
                        input logic [41:0] got);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %0h seen %0h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge core_clk);
      #1;
      param_wr    = 1'b1;
      param_addr  = a;
      param_wdata = d;
      @(posedge core_clk);
      #1;
      param_wr = 1'b0;
   endtask

   task automatic rd_chk(input string nm, input logic [15:0] a,
                         input logic [15:0] exp);
      @(posedge core_clk);
      #1;
      param_rd   = 1'b1;
      param_addr = a;
      @(posedge core_clk);
      #1;
      param_rd = 1'b0;
      check(nm, 42'(exp), 42'(param_rdata));
   endtask

   task automatic test_done;
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic reset_values;
      rd_chk("prop", speed_tune_pkg::ADDR_PROP_GAIN, 16'h01f4);
      rd_chk("integ", speed_tune_pkg::ADDR_INTEG_GAIN, 16'h0064);
      rd_chk("ff", speed_tune_pkg::ADDR_FF_GAIN, 16'h0000);
      rd_chk("mode", speed_tune_pkg::ADDR_MODE, 16'h0000);
      rd_chk("unmapped", 16'h0300, 16'h0000);
      check("run", 42'h0, 42'(est_run));
   endtask

   task automatic range_limits;
      logic [15:0] a [3];
      logic [15:0] m [3];
      a = '{speed_tune_pkg::ADDR_PROP_GAIN, speed_tune_pkg::ADDR_INTEG_GAIN,
            speed_tune_pkg::ADDR_FF_GAIN};
      m = '{16'h1fff, 16'h03ff, 16'h0064};
      for (int i = 0; i < 3; i++)
      begin
         wr(a[i], m[i]);
         rd_chk("max", a[i], m[i]);
         wr(a[i], m[i] + 16'h0001);
         rd_chk("above max", a[i], m[i]);
      end
      wr(speed_tune_pkg::ADDR_MODE, 16'h0003);
      rd_chk("mode 3", speed_tune_pkg::ADDR_MODE, 16'h0000);
   endtask

   task automatic manual_control;
      ce = 1'b0;
      wr(speed_tune_pkg::ADDR_FILT_B, 16'h0044);
      ce = 1'b1;
      rd_chk("filt_b frozen", speed_tune_pkg::ADDR_FILT_B, 16'h0000);
      wr(speed_tune_pkg::ADDR_FILT_A, 16'h0033);
      rd_chk("filt_a", speed_tune_pkg::ADDR_FILT_A, 16'h0033);
      wr(speed_tune_pkg::ADDR_INTEG_GAIN, 16'h0000);
      wr(speed_tune_pkg::ADDR_FF_GAIN, 16'h0000);
      wr(speed_tune_pkg::ADDR_PROP_GAIN, 16'h0003);
      wr(speed_tune_pkg::ADDR_FF_GAIN, 16'h0032);
      speed_cmd = 16'sd100;
      speed_fb  = 16'sd40;
      @(posedge core_clk);
      @(posedge core_clk);
      #1;
      check("ctrl", 42'd230, ctrl_out);
      speed_cmd = 16'sd0;
      speed_fb  = 16'sd0;
   endtask

   task automatic auto_mode;
      est_inertia = 16'h0077;
      wr(speed_tune_pkg::ADDR_STIFFNESS, 16'h0005);
      check("stiffness", 42'h5, 42'(stiffness));
      wr(speed_tune_pkg::ADDR_INERTIA, 16'h000c);
      wr(speed_tune_pkg::ADDR_MODE, 16'h0001);
      check("run auto", 42'h1, 42'(est_run));
      wr(speed_tune_pkg::ADDR_PROP_GAIN, 16'h0009);
      rd_chk("inertia early", speed_tune_pkg::ADDR_INERTIA, 16'h000c);
      repeat (20) @(posedge core_clk);
      rd_chk("inertia saved", speed_tune_pkg::ADDR_INERTIA, 16'h0077);
      rd_chk("prop locked", speed_tune_pkg::ADDR_PROP_GAIN, 16'h0003);
      est_inertia = 16'h0055;
      wr(speed_tune_pkg::ADDR_MODE, 16'h0000);
      check("run manual", 42'h0, 42'(est_run));
      rd_chk("inertia exit", speed_tune_pkg::ADDR_INERTIA, 16'h0055);
      rd_chk("first", speed_tune_pkg::ADDR_FIRST_GAIN, 16'h0011);
      rd_chk("prop", speed_tune_pkg::ADDR_PROP_GAIN, 16'h0022);
      rd_chk("integ", speed_tune_pkg::ADDR_INTEG_GAIN, 16'h002a);
      rd_chk("filt_a kept", speed_tune_pkg::ADDR_FILT_A, 16'h0033);
   endtask

   task automatic semi_mode;
      pulses = 0;
      wr(speed_tune_pkg::ADDR_MODE, 16'h0002);
      check("run semi", 42'h1, 42'(est_run));
      for (int i = 0; i < 4; i++)
      begin
         if (est_restart === 1'b1)
            pulses++;
         @(posedge core_clk);
         #1;
      end
      check("restart pulses", 42'h1, 42'(pulses));
      est_inertia = 16'h0066;
      est_stable  = 1'b1;
      @(posedge core_clk);
      @(posedge core_clk);
      #1;
      check("run stable", 42'h0, 42'(est_run));
      est_inertia = 16'h0044;
      rd_chk("flag", speed_tune_pkg::ADDR_STABLE, 16'h0001);
      rd_chk("inertia", speed_tune_pkg::ADDR_INERTIA, 16'h0066);
      est_out_of_range = 1'b1;
      @(posedge core_clk);
      #1;
      est_out_of_range = 1'b0;
      est_stable       = 1'b0;
      rd_chk("flag clr", speed_tune_pkg::ADDR_STABLE, 16'h0000);
      check("run again", 42'h1, 42'(est_run));
      wr(speed_tune_pkg::ADDR_MODE, 16'h0000);
      rd_chk("filt_a", speed_tune_pkg::ADDR_FILT_A, 16'h00a1);
      rd_chk("filt_b", speed_tune_pkg::ADDR_FILT_B, 16'h00b2);
      rd_chk("first", speed_tune_pkg::ADDR_FIRST_GAIN, 16'h0011);
   endtask

   // ----------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   initial
   begin
      #(40 * 5000);
      n_mismatch++;
      test_done();
   end

   initial
   begin
      n_mismatch       = 0;
      checks           = 0;
      arst_n           = 1'b0;
      ce               = 1'b1;
      param_wr         = 1'b0;
      param_rd         = 1'b0;
      param_addr       = 16'h0000;
      param_wdata      = 16'h0000;
      est_inertia      = 16'h0000;
      est_stable       = 1'b0;
      est_out_of_range = 1'b0;
      est_gains        = '{16'h0011, 16'h0022, 16'h002a, 16'h00a1, 16'h00b2};
      speed_cmd        = 16'sd0;
      speed_fb         = 16'sd0;
      repeat (16) @(posedge core_clk);
      #1;
      arst_n = 1'b1;
      reset_values();
      range_limits();
      manual_control();
      auto_mode();
      semi_mode();
      test_done();
   end
endmodule
`default_nettype wire
